// ### pcf_defs.svh
/*
 Constants of the pad configuration and function select block.
 Assumes inclusion by bare name from the block's design files.
*/
// Operation
// R1 - Each pin owns an 8-bit write-only pad configuration byte, fields bit 7..0.
// R2 - Pad bytes decode at the port 0..5 word ranges given below.
// R3 - All pad bytes reset to 0x00, everything disabled.
// R4 - Digital input buffer delivers data only while its bit is set.
// R5 - Hold latch weakly keeps the last actively driven pin level.
// R6 - Weak pull-up and pull-down follow their bits.
// R7 - Analog switch connects pin to the analog path while set.
// R8 - High-side and low-side drivers each follow their own bit.
// R9 - Input invert delivers the inverse pin level.
// R10 - Software picks push-pull, open drain/source, analog or oscillator combinations.
// R11 - Software sets input, hold, pull-up and low driver for quasi-bidirectional use.
// R12 - Crystal oscillator on forces port 2 pins 0 and 1 to high impedance.
// R13 - Real-time clock on forces analog switch of port 5 pins 6, 7; the code forces pins 40 and 41 instead, which are port 5 pins 0 and 1.
// R14 - Open-drain pins lack high-side driver and analog switch.
// R15 - Function select for port 0 pin 0 at 0xA050, reset 0x00.
// R16 - Software sets at most one function select bit at a time.
// R17 - Pin interrupt fires on rising edge if edge bit 1, else falling.
// R18 - Pin drives the interrupt line only while interrupt select is set.
// R19 - Analog channel connects only with channel select and analog switch set.
// R20 - General-purpose port function only while port select is set.
// R21 - Reads of pad configuration bytes return zero.
`ifndef PCF_DEFS_SVH
`define PCF_DEFS_SVH
// Register indices; byte address is four times the index
`define PCF_P0_BASE 16'hA040
`define PCF_P1_BASE 16'hA048
`define PCF_P2_BASE 16'hA060
`define PCF_P3_BASE 16'hA068
`define PCF_P4_BASE 16'hA0C0
`define PCF_P5_BASE 16'hA0AE
`define PCF_FSEL_IDX 16'hA050
// Pad byte fields
`define PCF_B_INBUF 7
`define PCF_B_HOLD 6
`define PCF_B_PU 5
`define PCF_B_PD 4
`define PCF_B_AN 3
`define PCF_B_HS 2
`define PCF_B_LS 1
`define PCF_B_INV 0
// Function select fields
`define PCF_F_EDGE 3
`define PCF_F_ACH 2
`define PCF_F_IRQ 1
`define PCF_F_GPIO 0
// Reset values
`define PCF_PAD_RST 8'h00
`define PCF_FSEL_RST 4'h0
// Pin indices of overridden pins
`define PCF_XIN_IDX 16
`define PCF_XOUT_IDX 17
`define PCF_RTC0_IDX 40
`define PCF_RTC1_IDX 41
// Open-drain pins: P1.2, P1.3, P4.0, P4.1, P4.3
`define PCF_OD_MASK 42'h0B00000C00
`endif

// ### pcf_pkg.sv
/*
 Types of the pad configuration and function select block.
 Assumes the constants header is compiled alongside.
*/
package pcf_pkg;
  typedef logic [7:0] pcf_pad_t;
  // Function of port 0 pin 0, one-hot
  typedef enum logic [3:0] {
    PCF_FN_NONE = 4'h0,
    PCF_FN_GPIO = 4'h1,
    PCF_FN_IRQ = 4'h2,
    PCF_FN_ACH = 4'h4
  } pcf_func_e;
endpackage

// ### pcf_pad_config.sv
/*
 Pad configuration for 42 pins and function select of port 0 pin 0,
 reached over an AHB-Lite slave. Assumes one clock, the pad analog
 cells outside, and pin levels arriving asynchronously.
*/
`timescale 1ns/1ps
`include "pcf_defs.svh"
module pcf_pad_config
  import pcf_pkg::*;
#(
  parameter int NPINS = 42
)(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Clock source overrides
  input wire logic xoscEn,
  input wire logic rtcEn,
  // Core side data
  input wire logic [NPINS-1:0] gpioOut,
  output logic [NPINS-1:0] gpioIn,
  // Pad pins
  input wire logic [NPINS-1:0] pinIn,
  output logic [NPINS-1:0] padOut,
  output logic [NPINS-1:0] padOutEnN,
  // Pad cell controls
  output logic [NPINS-1:0] inputBufEn,
  output logic [NPINS-1:0] holdEn,
  output logic [NPINS-1:0] holdLevel,
  output logic [NPINS-1:0] pullUpEn,
  output logic [NPINS-1:0] pullDownEn,
  output logic [NPINS-1:0] analogSwEn,
  output logic [NPINS-1:0] highSideEn,
  output logic [NPINS-1:0] lowSideEn,
  // Port 0 pin 0 functions
  output logic portFuncOn,
  output logic analogChannelEn,
  output logic pinIrqLine
);

  // ********************************
  // Address decode
  // ********************************
  localparam logic [5:0] NO_PAD = 6'h3F;

  // Word index to pin index, NO_PAD when unmapped
  function automatic logic [5:0] padIndex(input logic [31:0] a);
    logic [15:0] w;
    logic [5:0] r;
    w = a[17:2];
    r = NO_PAD;
    if (a[31:18] == 14'h0000 && a[1:0] == 2'b00)
    begin
      if (w >= `PCF_P0_BASE && w <= `PCF_P0_BASE + 16'h000F)
        r = 6'(w - `PCF_P0_BASE);
      else if (w >= `PCF_P2_BASE && w <= `PCF_P2_BASE + 16'h000F)
        r = 6'(w - `PCF_P2_BASE + 16'h0010);
      else if (w >= `PCF_P4_BASE && w <= `PCF_P4_BASE + 16'h0007)
        r = 6'(w - `PCF_P4_BASE + 16'h0020);
      else if (w >= `PCF_P5_BASE && w <= `PCF_P5_BASE + 16'h0001)
        r = 6'(w - `PCF_P5_BASE + 16'h0028);
    end
    return r;
  endfunction

  function automatic logic isFsel(input logic [31:0] a);
    return a[31:18] == 14'h0000 && a[1:0] == 2'b00 && a[17:2] == `PCF_FSEL_IDX;
  endfunction

  // ********************************
  // AHB-Lite slave
  // ********************************
  logic accept;
  logic wrPend_q;
  logic [5:0] wrIdx_q;
  logic wrFsel_q;
  logic [31:0] hrdata_q;
  pcf_pad_t pad_q [NPINS];
  logic [3:0] fsel_q;
  logic [3:0] fselNow;

  assign accept = hsel && hready && htrans[1];
  // Zero wait states; every access answers OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wrPend_q <= 1'b0;
      wrIdx_q <= NO_PAD;
      wrFsel_q <= 1'b0;
    end
    else
    begin
      wrPend_q <= accept && hwrite;
      wrIdx_q <= padIndex(haddr);
      wrFsel_q <= isFsel(haddr);
    end
  end

  // Forward a pending write so a read right behind it sees new data
  assign fselNow = (wrPend_q && wrFsel_q) ? hwdata[3:0] : fsel_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      hrdata_q <= 32'h0000_0000;
    else if (accept && !hwrite && isFsel(haddr))
      hrdata_q <= {28'h000_0000, fselNow};
    else
      hrdata_q <= 32'h0000_0000; // [R21]
  end

  // ********************************
  // Configuration registers
  // ********************************
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < NPINS; i++)
        pad_q[i] <= `PCF_PAD_RST; // [R3]
    end
    else if (wrPend_q && wrIdx_q != NO_PAD && int'(wrIdx_q) < NPINS)
      pad_q[wrIdx_q] <= hwdata[7:0]; // [R1] [R2]
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      fsel_q <= `PCF_FSEL_RST; // [R15]
    else if (wrPend_q && wrFsel_q)
      fsel_q <= hwdata[3:0]; // [R15]
  end

  // ********************************
  // Function select of pin 0
  // ********************************
  logic irqSel;
  logic achSel;

  // Software keeps a single bit of 2..0 set; several of those select nothing, edge bit 3 is masked
  always_comb
  begin
    portFuncOn = 1'b0;
    irqSel = 1'b0;
    achSel = 1'b0;
    case (pcf_func_e'(fsel_q & 4'h7)) // [R16]
      PCF_FN_GPIO: portFuncOn = 1'b1; // [R20]
      PCF_FN_IRQ: irqSel = 1'b1; // [R18]
      PCF_FN_ACH: achSel = 1'b1;
      default: portFuncOn = 1'b0;
    endcase
  end

  // ********************************
  // Pin synchroniser
  // ********************************
  logic [NPINS-1:0] pinMeta_q;
  logic [NPINS-1:0] pinSync_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      pinMeta_q <= '0;
      pinSync_q <= '0;
    end
    else
    begin
      pinMeta_q <= pinIn;
      pinSync_q <= pinMeta_q;
    end
  end

  // ********************************
  // Pad control
  // ********************************
  localparam logic [NPINS-1:0] OD_MASK = `PCF_OD_MASK;
  logic [NPINS-1:0] rawIn;

  always_comb
  begin
    for (int i = 0; i < NPINS; i++)
    begin
      inputBufEn[i] = pad_q[i][`PCF_B_INBUF];
      holdEn[i] = pad_q[i][`PCF_B_HOLD];
      pullUpEn[i] = pad_q[i][`PCF_B_PU]; // [R6]
      pullDownEn[i] = pad_q[i][`PCF_B_PD]; // [R6]
      analogSwEn[i] = pad_q[i][`PCF_B_AN] && !OD_MASK[i]; // [R7] [R14]
      highSideEn[i] = pad_q[i][`PCF_B_HS] && !OD_MASK[i]; // [R8] [R14]
      lowSideEn[i] = pad_q[i][`PCF_B_LS]; // [R8]
      // Oscillator pins go fully high impedance
      if (xoscEn && (i == `PCF_XIN_IDX || i == `PCF_XOUT_IDX))
      begin
        inputBufEn[i] = 1'b0; // [R12]
        holdEn[i] = 1'b0;
        pullUpEn[i] = 1'b0;
        pullDownEn[i] = 1'b0;
        analogSwEn[i] = 1'b0;
        highSideEn[i] = 1'b0;
        lowSideEn[i] = 1'b0;
      end
      if (rtcEn && (i == `PCF_RTC0_IDX || i == `PCF_RTC1_IDX))
        analogSwEn[i] = 1'b1; // [R13]
      // Pin 0 keeps port drive only in its port function
      if (i == 0 && !portFuncOn)
      begin
        highSideEn[i] = 1'b0; // [R20]
        lowSideEn[i] = 1'b0;
      end
      padOut[i] = gpioOut[i];
      // Each half drives only the level it can make
      padOutEnN[i] = !((highSideEn[i] && gpioOut[i]) ||
                       (lowSideEn[i] && !gpioOut[i])); // [R8] [R10] [R11]
      rawIn[i] = inputBufEn[i] && (pinSync_q[i] ^ pad_q[i][`PCF_B_INV]); // [R4] [R9]
      gpioIn[i] = rawIn[i];
    end
    gpioIn[0] = rawIn[0] && portFuncOn; // [R20]
  end

  // Own drive wins; otherwise follow the pin so the keeper holds
  // whatever an outside driver left behind
  logic [NPINS-1:0] holdLevel_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      holdLevel_q <= '0;
    else
    begin
      for (int i = 0; i < NPINS; i++)
        holdLevel_q[i] <= !padOutEnN[i] ? padOut[i] : pinSync_q[i]; // [R5]
    end
  end

  assign holdLevel = holdLevel_q;
  // Switch closes only with both bits set
  assign analogChannelEn = achSel && analogSwEn[0]; // [R19]

  // ********************************
  // Pin interrupt
  // ********************************
  logic irqPrev_q;
  logic pinIrq_q;
  logic irqHit;

  assign irqHit = fsel_q[`PCF_F_EDGE] ? (rawIn[0] && !irqPrev_q)
                                      : (!rawIn[0] && irqPrev_q); // [R17]

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      irqPrev_q <= 1'b0;
      pinIrq_q <= 1'b0;
    end
    else
    begin
      irqPrev_q <= rawIn[0];
      pinIrq_q <= irqSel && irqHit; // [R17] [R18]
    end
  end

  assign pinIrqLine = pinIrq_q;

  // ********************************
  // Checks
  // ********************************
  AST_PAD_READ_ZERO: assert property (@(posedge clk) disable iff (!resetn) // [R21]
    accept && !hwrite && padIndex(haddr) != NO_PAD |=> hrdata == 32'h0000_0000)
    else $error("pad configuration read not zero");

  AST_PAD_WRITE: assert property (@(posedge clk) disable iff (!resetn) // [R2]
    wrPend_q && wrIdx_q == 6'h10 |=> pad_q[16] == $past(hwdata[7:0]))
    else $error("pad write lost");

  AST_RESET_CLEAR: assert property (@(posedge clk) // [R3]
    !resetn |=> pad_q[0] == 8'h00 && pad_q[41] == 8'h00 && fsel_q == 4'h0)
    else $error("registers not cleared by reset");

  AST_CRYSTAL_OSCILLATOR_HIZ: assert property (@(posedge clk) disable iff (!resetn) // [R12]
    xoscEn |-> padOutEnN[17:16] == 2'b11 && pullUpEn[17:16] == 2'b00
      && pullDownEn[17:16] == 2'b00 && holdEn[17:16] == 2'b00)
    else $error("oscillator pins not high impedance");

  AST_RTC_ANALOG: assert property (@(posedge clk) disable iff (!resetn) // [R13]
    rtcEn |-> analogSwEn[41:40] == 2'b11)
    else $error("clock pins analog switch not forced");

  AST_OD_NO_HIGH: assert property (@(posedge clk) disable iff (!resetn) // [R14]
    (highSideEn & OD_MASK) == '0 && (analogSwEn & OD_MASK) == '0)
    else $error("open-drain pin has high side or analog");

  AST_INPUT_GATED: assert property (@(posedge clk) disable iff (!resetn) // [R4]
    gpioIn[9] |-> inputBufEn[9])
    else $error("input without buffer enabled");

  AST_DRIVE_NEEDS_EN: assert property (@(posedge clk) disable iff (!resetn) // [R8]
    !padOutEnN[13] |-> (gpioOut[13] ? highSideEn[13] : lowSideEn[13]))
    else $error("pin driven without matching driver");

  AST_IRQ_RISE: assert property (@(posedge clk) disable iff (!resetn) // [R17]
    irqSel && fsel_q[`PCF_F_EDGE] && rawIn[0] && !irqPrev_q |=> pinIrqLine)
    else $error("rising edge interrupt missed");

  AST_IRQ_ONLY_SEL: assert property (@(posedge clk) disable iff (!resetn) // [R18]
    pinIrqLine |-> $past(irqSel) && $past(rawIn[0]) == $past(fsel_q[`PCF_F_EDGE]))
    else $error("interrupt without select or wrong edge");

  AST_PORT_OFF: assert property (@(posedge clk) disable iff (!resetn) // [R20]
    !portFuncOn |-> padOutEnN[0] && !gpioIn[0])
    else $error("pin 0 port function active while deselected");

  AST_FSEL_WRITE: assert property (@(posedge clk) disable iff (!resetn) // [R15]
    wrPend_q && wrFsel_q |=> fsel_q == $past(hwdata[3:0]))
    else $error("function select write lost");

  AST_ACH_NEEDS_SWITCH: assert property (@(posedge clk) disable iff (!resetn) // [R19]
    analogChannelEn |-> analogSwEn[0] && fsel_q[`PCF_F_ACH])
    else $error("analog channel without switch and select");

  AST_HOLD_OWN: assert property (@(posedge clk) disable iff (!resetn) // [R5]
    !padOutEnN[13] |=> holdLevel[13] == $past(padOut[13]))
    else $error("keeper missed own driven level");

  AST_IRQ_PULSE: assert property (@(posedge clk) disable iff (!resetn) // [R17]
    pinIrqLine |=> !pinIrqLine)
    else $error("pin interrupt wider than one cycle");

endmodule

// ### pcf_pad_config_tb_top.sv
/*
 Self-checking testbench of the pad configuration block.
 Assumes the block's header and package are compiled first.
*/
`timescale 1ns/1ps
`include "pcf_defs.svh"
module pcf_pad_config_tb_top
  import pcf_pkg::*;
;
  // ****************************************
  // Signals and instance
  // ****************************************
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic xoscEn = 1'b0;
  logic rtcEn = 1'b0;
  logic [41:0] gpioOut = 42'h0;
  logic [41:0] gpioIn;
  logic [41:0] pinIn = 42'h0;
  logic [41:0] padOut, padOutEnN, inputBufEn, holdEn, holdLevel, pullUpEn;
  logic [41:0] pullDownEn, analogSwEn, highSideEn, lowSideEn;
  logic portFuncOn, analogChannelEn, pinIrqLine;
  int n_errors = 0;
  int tests_run = 0;
  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;
  pcf_pad_config #(.NPINS(42)) dut_u (.clk(clk), .resetn(resetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .xoscEn(xoscEn), .rtcEn(rtcEn), .gpioOut(gpioOut), .gpioIn(gpioIn), .pinIn(pinIn),
    .padOut(padOut), .padOutEnN(padOutEnN), .inputBufEn(inputBufEn), .holdEn(holdEn),
    .holdLevel(holdLevel), .pullUpEn(pullUpEn), .pullDownEn(pullDownEn),
    .analogSwEn(analogSwEn), .highSideEn(highSideEn), .lowSideEn(lowSideEn),
    .portFuncOn(portFuncOn), .analogChannelEn(analogChannelEn), .pinIrqLine(pinIrqLine));
  initial
  begin
    forever #5 clk = ~clk;
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(string name, logic [63:0] seen, logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Waits on bus ready, bounded so a stuck slave counts as a fault
  task automatic wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (hready !== 1'b1 && k < 50);
    if (k >= 50)
      check("hready", 1'b0, 1'b1);
  endtask
  task automatic bus(logic wr, logic [31:0] addr, logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_rdy();
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check("hresp", hresp, 1'b0);
  endtask
  function automatic logic [31:0] regAddr(int idx);
    return 32'(idx) << 2;
  endfunction
  function automatic int padIdx(int p);
    if (p < 8) return `PCF_P0_BASE + p;
    if (p < 16) return `PCF_P1_BASE + p - 8;
    if (p < 24) return `PCF_P2_BASE + p - 16;
    if (p < 32) return `PCF_P3_BASE + p - 24;
    if (p < 40) return `PCF_P4_BASE + p - 32;
    return `PCF_P5_BASE + p - 40;
  endfunction
  task automatic wr(int idx, logic [31:0] d);
    logic [31:0] rd;
    bus(1'b1, regAddr(idx), d, rd);
    @(negedge clk);
  endtask
  task automatic rdchk(string name, int idx, logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, regAddr(idx), 32'h0, rd);
    check(name, rd, exp);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    @(negedge clk);
    check("inputBufEn", inputBufEn, 42'h0);
    check("holdEn", holdEn, 42'h0);
    check("pullUpEn", pullUpEn, 42'h0);
    check("pullDownEn", pullDownEn, 42'h0);
    check("analogSwEn", analogSwEn, 42'h0);
    check("highSideEn", highSideEn, 42'h0);
    check("lowSideEn", lowSideEn, 42'h0);
    check("holdLevel", holdLevel, 42'h0);
    check("padOutEnN", padOutEnN, {42{1'b1}});
    rdchk("fsel reset", `PCF_FSEL_IDX, 32'h0);
  endtask
  task automatic t_decode;
    int pins[12] = '{1, 7, 8, 15, 16, 23, 24, 31, 32, 39, 40, 41};
    logic [41:0] mask;
    mask = '0;
    foreach (pins[i])
    begin
      wr(padIdx(pins[i]), 32'h20);
      mask[pins[i]] = 1'b1;
    end
    // Holes next to the pad ranges must not alias onto any pin
    wr(16'hA0C8, 32'h20);
    wr(16'hA070, 32'h20);
    wr(16'hA058, 32'h20);
    check("decode pullUpEn", pullUpEn, mask);
  endtask
  task automatic t_fields;
    logic [6:0] ctl;
    for (int b = 1; b < 8; b++)
    begin
      wr(padIdx(8), 32'h1 << b);
      ctl = {inputBufEn[8], holdEn[8], pullUpEn[8], pullDownEn[8], analogSwEn[8],
        highSideEn[8], lowSideEn[8]};
      check("pad field", ctl, 7'(8'h1 << b >> 1));
      rdchk("pad read", padIdx(8), 32'h0);
    end
  endtask
  task automatic t_invert;
    @(posedge clk);
    pinIn[9] <= 1'b1;
    wr(padIdx(9), 32'h80);
    repeat (3) @(negedge clk);
    check("gpioIn plain", gpioIn[9], 1'b1);
    wr(padIdx(9), 32'h81);
    check("gpioIn inverted", gpioIn[9], 1'b0);
    wr(padIdx(9), 32'h00);
    check("gpioIn buffer off", gpioIn[9], 1'b0);
  endtask
  task automatic t_overrides;
    wr(padIdx(16), 32'hFF);
    @(posedge clk);
    xoscEn <= 1'b1;
    @(negedge clk);
    check("crystal_oscillator ctl", {inputBufEn[16], pullUpEn[16], highSideEn[16], lowSideEn[16]}, 0);
    check("crystal_oscillator hiz", padOutEnN[16], 1'b1);
    @(posedge clk);
    xoscEn <= 1'b0;
    rtcEn <= 1'b1;
    @(negedge clk);
    check("crystal_oscillator off", inputBufEn[16], 1'b1);
    check("rtc analog", analogSwEn[41:40], 2'b11);
    @(posedge clk);
    rtcEn <= 1'b0;
    @(negedge clk);
    check("rtc off", analogSwEn[41:40], 2'b00);
    wr(padIdx(10), 32'h0E);
    check("od pin", {analogSwEn[10], highSideEn[10], lowSideEn[10]}, 3'b001);
  endtask
  task automatic t_modes;
    wr(padIdx(13), 32'h46);
    @(posedge clk);
    gpioOut[13] <= 1'b1;
    repeat (2) @(negedge clk);
    check("push-pull en", padOutEnN[13], 1'b0);
    check("push-pull out", padOut[13], 1'b1);
    check("hold driven", holdLevel[13], 1'b1);
    wr(padIdx(13), 32'h02);
    check("open drain high", padOutEnN[13], 1'b1);
    wr(padIdx(12), 32'hE2);
    check("quasi low", padOutEnN[12], 1'b0);
    @(posedge clk);
    gpioOut[12] <= 1'b1;
    pinIn[12] <= 1'b1;
    repeat (4) @(negedge clk);
    check("quasi release", padOutEnN[12], 1'b1);
    check("quasi input", gpioIn[12], 1'b1);
    check("hold pin", holdLevel[12], 1'b1);
  endtask
  task automatic t_fsel;
    logic [11:0] modes[5] = '{12'h100, 12'h408, 12'h400, 12'h508, 12'h208};
    wr(`PCF_FSEL_IDX, 32'hFFFFFFFF);
    rdchk("fsel width", `PCF_FSEL_IDX, 32'hF);
    foreach (modes[i])
    begin
      wr(padIdx(0), {24'h0, modes[i][7:0]});
      wr(`PCF_FSEL_IDX, {28'h0, modes[i][11:8]});
      check("portFuncOn", portFuncOn, modes[i] == 12'h100);
      check("analogChannelEn", analogChannelEn, modes[i] == 12'h408);
    end
  endtask
  task automatic irq_edge(logic v, logic exp);
    int cnt;
    int pos;
    cnt = 0;
    pos = 0;
    @(posedge clk);
    pinIn[0] <= v;
    for (int k = 1; k <= 6; k++)
    begin
      @(negedge clk);
      cnt += int'(pinIrqLine === 1'b1);
      pos += (pinIrqLine === 1'b1) ? k : 0;
    end
    check("irq count", cnt, exp ? 1 : 0);
    check("irq time", pos, exp ? 4 : 0);
  endtask
  task automatic t_irq;
    logic [3:0] fs[4] = '{4'hA, 4'h2, 4'h0, 4'hB};
    logic [7:0] ex[4] = '{8'h10, 8'h01, 8'h00, 8'h00};
    wr(padIdx(0), 32'h80);
    foreach (fs[i])
    begin
      wr(`PCF_FSEL_IDX, {28'h0, fs[i]});
      irq_edge(1'b1, ex[i][4]);
      irq_edge(1'b0, ex[i][0]);
    end
  endtask
  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  initial
  begin
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_decode();
    t_fields();
    t_invert();
    t_overrides();
    t_modes();
    t_fsel();
    t_irq();
    final_report();
  end
  // Whole run needs well under a thousand cycles
  initial
  begin
    #100000;
    n_errors++;
    final_report();
  end
endmodule
